/* File: core/serial_message_framer.sv */
// serial message framer: parses host frames, builds device frames
// What this block does
// - every frame starts with ampersand byte
// - every frame ends with percent byte
// - length word counts whole message bytes
// - ccitt frame_check_word, poly 1021, init FFFF
// - crc skips delimiters, sits before end
// - acknowledge frame field order fixed
// - device acknowledges host command requests; a newer one overwrites an ack still pending
// - ack sequence equals acknowledged frame sequence
// - command response follows fixed field order
// - device payloads hold zero to 63 bytes
// - async responses share response layout
// - flow control frames carry no payload
// - status frames use response layout
// - codes are words, sequences are bytes
`timescale 1ns/1ps
`default_nettype none
module serial_message_framer
  import serial_message_framer_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [7:0] rx_byte,
  input wire logic rx_valid,
  input wire logic [15:0] ack_code,
  input wire logic [15:0] host_reply_cmd,
  input wire logic [15:0] host_flow_cmd,
  output rx_hdr_t rx_hdr,
  output logic [7:0] rx_body_byte,
  output logic rx_body_valid,
  output logic rx_done,
  output logic rx_good,
  input wire logic tx_start,
  input wire tx_req_t tx_req,
  input wire logic [7:0] tx_data,
  input wire logic tx_data_valid,
  output logic tx_data_take,
  output logic tx_busy,
  output logic [7:0] line_byte,
  output logic line_valid,
  input wire logic line_ready
);

  typedef enum {R_HUNT, R_LEN, R_SEQ, R_CMD, R_CSEQ, R_BODY, R_CRC, R_EOM} rx_state_t;
  typedef enum {T_IDLE, T_SOM, T_LEN, T_SEQ, T_CMD, T_CSEQ, T_CODE, T_ACKSEQ, T_DATA,
    T_CRC, T_EOM} tx_state_t;

  rx_state_t rx_st_ff, nxt_rx_st;
  logic rx_hi_ff, nxt_rx_hi;
  logic [7:0] rx_cnt_ff, nxt_rx_cnt;
  logic [15:0] rx_crc_ff, nxt_rx_crc;
  rx_hdr_t rx_hdr_ff, nxt_rx_hdr;
  logic [7:0] rx_body_byte_ff, nxt_rx_body_byte;
  logic rx_body_valid_ff, nxt_rx_body_valid;
  logic rx_done_ff, nxt_rx_done;
  logic rx_good_ff, nxt_rx_good;
  logic ack_pend_ff, nxt_ack_pend;
  rx_hdr_t ack_hdr_ff, nxt_ack_hdr;

  tx_state_t tx_st_ff, nxt_tx_st;
  tx_req_t cur_ff, nxt_cur;
  logic is_ack_ff, nxt_is_ack;
  logic [7:0] ack_seq_ff, nxt_ack_seq;
  logic tx_hi_ff, nxt_tx_hi;
  logic [5:0] tx_cnt_ff, nxt_tx_cnt;
  logic [15:0] tx_crc_ff, nxt_tx_crc;
  logic [7:0] tx_seq_ff, nxt_tx_seq;
  logic [7:0] line_byte_ff, nxt_line_byte;
  logic line_valid_ff, nxt_line_valid;
  logic tx_take_ff, nxt_tx_take;
  logic tx_busy_ff, nxt_tx_busy;

  logic ack_sent;
  logic [7:0] rx_cnt_inc;
  logic [7:0] body_end;
  logic [15:0] frame_len;
  logic [15:0] tx_word;
  logic advance;
  logic emit;
  logic crc_on;

  assign rx_cnt_inc = rx_cnt_ff + 8'h01;
  assign body_end = rx_hdr_ff.len[7:0] - TAIL_BYTES;
  assign advance = !line_valid_ff || line_ready;

  // receive side
  always_comb
  begin
    nxt_rx_st = rx_st_ff;
    nxt_rx_hi = rx_hi_ff;
    nxt_rx_cnt = rx_cnt_ff;
    nxt_rx_crc = rx_crc_ff;
    nxt_rx_hdr = rx_hdr_ff;
    nxt_rx_body_byte = rx_body_byte_ff;
    nxt_rx_body_valid = 1'b0;
    nxt_rx_done = 1'b0;
    nxt_rx_good = rx_good_ff;
    nxt_ack_pend = ack_pend_ff;
    nxt_ack_hdr = ack_hdr_ff;
    if (ack_sent)
    begin
      nxt_ack_pend = 1'b0;
    end
    if (rx_valid)
    begin
      nxt_rx_cnt = rx_cnt_inc;
      if (rx_st_ff != R_HUNT && rx_st_ff != R_EOM)
      begin
        nxt_rx_crc = crc_step(rx_crc_ff, rx_byte);
      end
      unique case (rx_st_ff)
        R_HUNT:
          if (rx_byte == SOF_BYTE)
          begin
            nxt_rx_st = R_LEN;
            nxt_rx_hi = 1'b1;
            nxt_rx_cnt = 8'h01;
            nxt_rx_crc = CRC_INIT;
          end
        R_LEN:
          if (rx_hi_ff)
          begin
            nxt_rx_hdr.len[15:8] = rx_byte;
            nxt_rx_hi = 1'b0;
          end
          else
          begin
            nxt_rx_hdr.len[7:0] = rx_byte;
            nxt_rx_hi = 1'b1;
            // length outside a request's range cannot frame properly
            if ({rx_hdr_ff.len[15:8], rx_byte} >= MIN_RX_LEN &&
                {rx_hdr_ff.len[15:8], rx_byte} <= MAX_RX_LEN)
            begin
              nxt_rx_st = R_SEQ;
            end
            else
            begin
              nxt_rx_st = R_HUNT;
              nxt_rx_done = 1'b1;
              nxt_rx_good = 1'b0;
            end
          end
        R_SEQ:
        begin
          nxt_rx_hdr.message_sequence_byte = rx_byte;
          nxt_rx_st = R_CMD;
        end
        R_CMD:
          if (rx_hi_ff)
          begin
            nxt_rx_hdr.cmd[15:8] = rx_byte;
            nxt_rx_hi = 1'b0;
          end
          else
          begin
            nxt_rx_hdr.cmd[7:0] = rx_byte;
            nxt_rx_st = R_CSEQ;
          end
        R_CSEQ:
        begin
          nxt_rx_hdr.command_sequence_byte = rx_byte;
          nxt_rx_hi = 1'b1;
          nxt_rx_st = (rx_cnt_inc == body_end) ? R_CRC : R_BODY;
        end
        R_BODY:
        begin
          nxt_rx_body_byte = rx_byte;
          nxt_rx_body_valid = 1'b1;
          if (rx_cnt_inc == body_end)
          begin
            nxt_rx_st = R_CRC;
          end
        end
        R_CRC:
          if (rx_hi_ff)
          begin
            nxt_rx_hi = 1'b0;
          end
          else
          begin
            nxt_rx_st = R_EOM;
          end
        R_EOM:
        begin
          nxt_rx_st = R_HUNT;
          nxt_rx_done = 1'b1;
          // a wrong byte count lands a non-end byte here
          nxt_rx_good = (rx_byte == EOF_BYTE) && (rx_crc_ff == CRC_RESIDUE);
          if (rx_byte == EOF_BYTE && rx_crc_ff == CRC_RESIDUE &&
              rx_hdr_ff.cmd != host_reply_cmd && rx_hdr_ff.cmd != host_flow_cmd)
          begin
            nxt_ack_pend = 1'b1;
            nxt_ack_hdr = rx_hdr_ff;
          end
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      rx_st_ff <= R_HUNT;
      rx_hi_ff <= 1'b0;
      rx_cnt_ff <= 8'h00;
      rx_crc_ff <= CRC_INIT;
      rx_hdr_ff <= '0;
      rx_body_byte_ff <= 8'h00;
      rx_body_valid_ff <= 1'b0;
      rx_done_ff <= 1'b0;
      rx_good_ff <= 1'b0;
      ack_pend_ff <= 1'b0;
      ack_hdr_ff <= '0;
    end
    else if (ce)
    begin
      rx_st_ff <= nxt_rx_st;
      rx_hi_ff <= nxt_rx_hi;
      rx_cnt_ff <= nxt_rx_cnt;
      rx_crc_ff <= nxt_rx_crc;
      rx_hdr_ff <= nxt_rx_hdr;
      rx_body_byte_ff <= nxt_rx_body_byte;
      rx_body_valid_ff <= nxt_rx_body_valid;
      rx_done_ff <= nxt_rx_done;
      rx_good_ff <= nxt_rx_good;
      ack_pend_ff <= nxt_ack_pend;
      ack_hdr_ff <= nxt_ack_hdr;
    end
  end

  // transmit side
  always_comb
  begin
    nxt_tx_st = tx_st_ff;
    nxt_cur = cur_ff;
    nxt_is_ack = is_ack_ff;
    nxt_ack_seq = ack_seq_ff;
    nxt_tx_hi = tx_hi_ff;
    nxt_tx_cnt = tx_cnt_ff;
    nxt_tx_crc = tx_crc_ff;
    nxt_tx_seq = tx_seq_ff;
    nxt_line_byte = line_byte_ff;
    nxt_line_valid = line_valid_ff;
    nxt_tx_take = 1'b0;
    ack_sent = 1'b0;
    emit = 1'b0;
    crc_on = 1'b1;
    frame_len = {8'h00, FRAME_OVERHEAD + (is_ack_ff ? ACK_EXTRA : {2'b00, cur_ff.data_len})};
    tx_word = 16'h0000;
    unique case (tx_st_ff)
      T_LEN: tx_word = frame_len;
      T_CMD: tx_word = cur_ff.cmd;
      T_CODE: tx_word = cur_ff.code;
      T_CRC: tx_word = tx_crc_ff;
      default: tx_word = 16'h0000;
    endcase
    if (advance)
    begin
      nxt_line_valid = 1'b0;
      unique case (tx_st_ff)
        T_IDLE:
          if (ack_pend_ff)
          begin
            nxt_cur = '{K_FLOW, ack_hdr_ff.cmd, ack_hdr_ff.command_sequence_byte, ack_code, 6'h00};
            nxt_ack_seq = ack_hdr_ff.message_sequence_byte;
            nxt_is_ack = 1'b1;
            ack_sent = 1'b1;
            nxt_tx_st = T_SOM;
          end
          else if (tx_start)
          begin
            nxt_cur = tx_req;
            if (tx_req.kind == K_FLOW)
            begin
              nxt_cur.data_len = 6'h00;
            end
            nxt_is_ack = 1'b0;
            nxt_tx_st = T_SOM;
          end
        T_SOM:
        begin
          emit = 1'b1;
          crc_on = 1'b0;
          nxt_line_byte = SOF_BYTE;
          nxt_tx_crc = CRC_INIT;
          nxt_tx_hi = 1'b1;
          nxt_tx_st = T_LEN;
        end
        T_LEN, T_CMD, T_CODE, T_CRC:
        begin
          emit = 1'b1;
          crc_on = (tx_st_ff != T_CRC);
          nxt_line_byte = tx_hi_ff ? tx_word[15:8] : tx_word[7:0];
          nxt_tx_hi = !tx_hi_ff;
          if (!tx_hi_ff)
          begin
            unique case (tx_st_ff)
              T_LEN: nxt_tx_st = T_SEQ;
              T_CMD: nxt_tx_st = T_CSEQ;
              T_CODE: nxt_tx_st = is_ack_ff ? T_ACKSEQ : ((cur_ff.data_len == 6'h00) ? T_CRC : T_DATA);
              default: nxt_tx_st = T_EOM;
            endcase
          end
        end
        T_SEQ:
        begin
          emit = 1'b1;
          nxt_line_byte = tx_seq_ff;
          nxt_tx_st = T_CMD;
        end
        T_CSEQ:
        begin
          emit = 1'b1;
          nxt_line_byte = cur_ff.command_sequence_byte;
          nxt_tx_cnt = 6'h00;
          nxt_tx_st = T_CODE;
        end
        T_ACKSEQ:
        begin
          emit = 1'b1;
          nxt_line_byte = ack_seq_ff;
          nxt_tx_st = T_CRC;
        end
        T_DATA:
          // one byte per take pulse, so the source sees each take before the next
          if (tx_data_valid && !tx_take_ff)
          begin
            emit = 1'b1;
            nxt_line_byte = tx_data;
            nxt_tx_take = 1'b1;
            nxt_tx_cnt = tx_cnt_ff + 6'h01;
            if (tx_cnt_ff + 6'h01 == cur_ff.data_len)
            begin
              nxt_tx_st = T_CRC;
            end
          end
        T_EOM:
        begin
          emit = 1'b1;
          crc_on = 1'b0;
          nxt_line_byte = EOF_BYTE;
          nxt_tx_seq = tx_seq_ff + 8'h01;
          nxt_tx_st = T_IDLE;
        end
      endcase
      if (emit)
      begin
        nxt_line_valid = 1'b1;
        if (crc_on)
        begin
          nxt_tx_crc = crc_step(tx_crc_ff, nxt_line_byte);
        end
      end
    end
    nxt_tx_busy = (nxt_tx_st != T_IDLE);
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      tx_st_ff <= T_IDLE;
      cur_ff <= '0;
      is_ack_ff <= 1'b0;
      ack_seq_ff <= 8'h00;
      tx_hi_ff <= 1'b0;
      tx_cnt_ff <= 6'h00;
      tx_crc_ff <= CRC_INIT;
      tx_seq_ff <= 8'h00;
      line_byte_ff <= 8'h00;
      line_valid_ff <= 1'b0;
      tx_take_ff <= 1'b0;
      tx_busy_ff <= 1'b0;
    end
    else if (ce)
    begin
      tx_st_ff <= nxt_tx_st;
      cur_ff <= nxt_cur;
      is_ack_ff <= nxt_is_ack;
      ack_seq_ff <= nxt_ack_seq;
      tx_hi_ff <= nxt_tx_hi;
      tx_cnt_ff <= nxt_tx_cnt;
      tx_crc_ff <= nxt_tx_crc;
      tx_seq_ff <= nxt_tx_seq;
      line_byte_ff <= nxt_line_byte;
      line_valid_ff <= nxt_line_valid;
      tx_take_ff <= nxt_tx_take;
      tx_busy_ff <= nxt_tx_busy;
    end
  end

  assign rx_hdr = rx_hdr_ff;
  assign rx_body_byte = rx_body_byte_ff;
  assign rx_body_valid = rx_body_valid_ff;
  assign rx_done = rx_done_ff;
  assign rx_good = rx_good_ff;
  assign tx_data_take = tx_take_ff;
  assign tx_busy = tx_busy_ff;
  assign line_byte = line_byte_ff;
  assign line_valid = line_valid_ff;

endmodule
`default_nettype wire

/* File: core/serial_message_framer_pkg.sv */
// shared constants, types and crc step for the serial message framer
package serial_message_framer_pkg;

  localparam logic [7:0] SOF_BYTE = 8'h26;
  localparam logic [7:0] EOF_BYTE = 8'h25;
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_RESIDUE = 16'h0000;
  // frame size without payload: start, len, seq, cmd, cseq, code, crc, end
  localparam logic [7:0] FRAME_OVERHEAD = 8'h0C;
  localparam logic [7:0] ACK_EXTRA = 8'h01;
  localparam logic [7:0] TAIL_BYTES = 8'h03;
  // request: 10 bytes bare, 65 payload bytes at most
  localparam logic [15:0] MIN_RX_LEN = 16'h000A;
  localparam logic [15:0] MAX_RX_LEN = 16'h004B;

  typedef enum logic [1:0] {K_RESPONSE, K_ASYNC, K_FLOW, K_STATUS} tx_kind_t;

  typedef struct packed {
    tx_kind_t kind;
    logic [15:0] cmd;
    logic [7:0] command_sequence_byte;
    logic [15:0] code;
    logic [5:0] data_len;
  } tx_req_t;

  typedef struct packed {
    logic [15:0] len;
    logic [7:0] message_sequence_byte;
    logic [15:0] cmd;
    logic [7:0] command_sequence_byte;
  } rx_hdr_t;

  // one byte through the ccitt crc, msb first
  function automatic logic [15:0] crc_step(input logic [15:0] crc, input logic [7:0] data);
    logic [15:0] c;
    c = crc ^ {data, 8'h00};
    for (int i = 0; i < 8; i++)
    begin
      c = c[15] ? ((c << 1) ^ CRC_POLY) : (c << 1);
    end
    return c;
  endfunction

endpackage

/* File: tb/host_line_model.sv */
// host side model: stalling line receiver and frame sender
`timescale 1ns/1ps
`default_nettype none
module host_line_model (
  input wire logic sys_clk,
  input wire logic [7:0] line_byte,
  input wire logic line_valid,
  output logic line_ready,
  input wire logic stall,
  output logic [7:0] rx_byte,
  output logic rx_valid
);
  logic [7:0] got[$];
  initial
  begin
    line_ready = 1'b1;
    rx_byte = 8'h00;
    rx_valid = 1'b0;
  end
  always @(posedge sys_clk)
  begin
    if (line_valid && line_ready)
    begin
      got.push_back(line_byte);
    end
    line_ready <= stall ? ~line_ready : 1'b1;
  end
  // bytes back to back, caller lays out the frame
  task automatic send(input logic [7:0] q[$]);
    foreach (q[i])
    begin
      @(posedge sys_clk);
      rx_valid <= 1'b1;
      rx_byte <= q[i];
    end
    @(posedge sys_clk);
    rx_valid <= 1'b0;
    rx_byte <= ~rx_byte;
  endtask
endmodule
`default_nettype wire

/* File: tb/serial_message_framer_assertions.sv */
// checker on the framer line and receive ports
`timescale 1ns/1ps
`default_nettype none
module serial_message_framer_assertions
  import serial_message_framer_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [7:0] line_byte,
  input wire logic line_valid,
  input wire logic line_ready,
  input wire logic tx_busy,
  input wire logic tx_data_take,
  input wire logic rx_done,
  input wire logic rx_body_valid
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  // payload bytes leave a one-cycle gap, so frame edges are told by busy
  frame_start_a: assert property (
    $rose(line_valid) && !$past(tx_busy, 2) |-> line_byte == SOF_BYTE)
    else $error("frame not opened by start byte");
  busy_start_a: assert property ($rose(tx_busy) |=> $rose(line_valid))
    else $error("busy rose without a start byte");
  frame_end_a: assert property (
    !$past(rst) && $fell(line_valid) && !$past(tx_busy) |-> $past(line_byte) == EOF_BYTE)
    else $error("frame not closed by end byte");
  line_hold_a: assert property (line_valid && !line_ready |=> line_valid && $stable(line_byte))
    else $error("line byte changed while stalled");
  len_high_a: assert property (
    $rose(line_valid) && !$past(tx_busy, 2) && line_ready && ce |=> line_byte == 8'h00)
    else $error("length high byte not zero");
  take_after_a: assert property (
    tx_data_take |-> line_valid && $past(ce) && (!$past(line_valid) || $past(line_ready)))
    else $error("payload take without a line accept");
  done_pulse_a: assert property (rx_done |=> !rx_done)
    else $error("done longer than one cycle");
  body_gap_a: assert property (rx_body_valid |=> !rx_done [*2])
    else $error("done before check word and end byte");
endmodule
`default_nettype wire

/* File: tb/serial_message_framer_tb.sv */
// self-checking bench for the serial message framer
`timescale 1ns/1ps
`default_nettype none
module serial_message_framer_tb
  import serial_message_framer_pkg::*;
;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic tx_start = 1'b0;
  tx_req_t tx_req = '0;
  // payload source counts up from A0 over the whole run
  logic [7:0] tx_data = 8'hA0;
  logic stall = 1'b0;
  logic [7:0] rx_byte, rx_body_byte, line_byte, tx_seq;
  logic rx_valid, rx_done, rx_good, rx_body_valid, tx_data_take, tx_busy, line_valid, line_ready;
  rx_hdr_t rx_hdr;
  int errors = 0;
  int samples_checked = 0;
  logic [7:0] fr[$];
  logic [7:0] body[$];
  always #20 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
  begin
    if (tx_data_take)
    begin
      tx_data <= tx_data + 8'h01;
    end
    if (rx_body_valid)
    begin
      body.push_back(rx_body_byte);
    end
  end
  serial_message_framer dut_u (.sys_clk(sys_clk), .rst(rst), .ce(1'b1), .rx_byte(rx_byte),
    .rx_valid(rx_valid), .ack_code(16'h5A5A), .host_reply_cmd(16'h0101),
    .host_flow_cmd(16'h0202), .rx_hdr(rx_hdr), .rx_body_byte(rx_body_byte),
    .rx_body_valid(rx_body_valid), .rx_done(rx_done), .rx_good(rx_good),
    .tx_start(tx_start), .tx_req(tx_req), .tx_data(tx_data), .tx_data_valid(1'b1),
    .tx_data_take(tx_data_take), .tx_busy(tx_busy), .line_byte(line_byte),
    .line_valid(line_valid), .line_ready(line_ready));
  host_line_model host_u (.sys_clk(sys_clk), .line_byte(line_byte), .line_valid(line_valid),
    .line_ready(line_ready), .stall(stall), .rx_byte(rx_byte), .rx_valid(rx_valid));
  function automatic logic [15:0] frame_check_word(input logic [7:0] q[$]);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (q[i])
    begin
      for (int b = 7; b >= 0; b--)
      begin
        c = {c[14:0], 1'b0} ^ ((c[15] ^ q[i][b]) ? 16'h1021 : 16'h0000);
      end
    end
    return c;
  endfunction
  task automatic frame(input logic [7:0] b[$]);
    logic [15:0] n;
    logic [15:0] c;
    n = 16'(b.size() + 6);
    fr = {n[15:8], n[7:0], b};
    c = frame_check_word(fr);
    fr = {8'h26, fr, c[15:8], c[7:0], 8'h25};
  endtask
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic check_line();
    for (int i = 0; i < 400 && host_u.got.size() < fr.size(); i++)
    begin
      @(negedge sys_clk);
    end
    cmp(16'(host_u.got.size()), 16'(fr.size()));
    foreach (fr[i])
    begin
      cmp({8'h00, host_u.got[i]}, {8'h00, fr[i]});
    end
    host_u.got.delete();
    tx_seq++;
  endtask
  task automatic wait_done();
    repeat (30)
    begin
      @(negedge sys_clk);
      if (rx_done === 1'b1)
      begin
        break;
      end
    end
    cmp({15'h0, rx_done}, 16'h0001);
  endtask
  // request with an ampersand in its payload, ack under line stall
  task automatic s_request();
    stall <= 1'b1;
    frame({8'h05, 8'h12, 8'h34, 8'h07, 8'hC1, 8'h26});
    host_u.send(fr);
    wait_done();
    cmp({15'h0, rx_good}, 16'h0001);
    cmp(rx_hdr.len, 16'h000C);
    cmp(rx_hdr.cmd, 16'h1234);
    cmp({rx_hdr.message_sequence_byte, rx_hdr.command_sequence_byte}, 16'h0507);
    cmp({body[0], body[1]}, 16'hC126);
    frame({tx_seq, 8'h12, 8'h34, 8'h07, 8'h5A, 8'h5A, 8'h05});
    check_line();
    stall <= 1'b0;
  endtask
  // bad check word, host ack and host flow frame: none answered
  task automatic s_reject();
    frame({8'h06, 8'h12, 8'h34, 8'h08});
    fr[fr.size() - 2] ^= 8'h01;
    host_u.send(fr);
    wait_done();
    cmp({15'h0, rx_good}, 16'h0000);
    frame({8'h07, 8'h01, 8'h01, 8'h09, 8'h00, 8'h00, 8'h00});
    host_u.send(fr);
    wait_done();
    cmp({15'h0, rx_good}, 16'h0001);
    frame({8'h08, 8'h02, 8'h02, 8'h0A, 8'h00, 8'h00});
    host_u.send(fr);
    wait_done();
    repeat (40) @(negedge sys_clk);
    cmp(16'(host_u.got.size()), 16'h0000);
  endtask
  // every frame kind, flow payload dropped, 63 byte status stalled
  task automatic s_tx();
    int lens[4] = '{0, 1, 5, 63};
    int n;
    int pay = 0;
    logic [7:0] b[$];
    for (int k = 0; k < 4; k++)
    begin
      n = (k == 2) ? 0 : lens[k];
      @(posedge sys_clk);
      stall <= (k == 3);
      tx_req <= '{tx_kind_t'(k), 16'h0300 + 16'(k), 8'h40 + 8'(k), 16'hBEE0 + 16'(k), 6'(lens[k])};
      tx_start <= 1'b1;
      repeat (20)
      begin
        @(negedge sys_clk);
        if (tx_busy === 1'b1)
        begin
          break;
        end
      end
      @(posedge sys_clk);
      tx_start <= 1'b0;
      b = {tx_seq, 8'h03, 8'(k), 8'h40 + 8'(k), 8'hBE, 8'hE0 + 8'(k)};
      for (int i = 0; i < n; i++)
      begin
        b.push_back(8'hA0 + 8'(pay));
        pay++;
      end
      frame(b);
      check_line();
    end
  endtask
  task automatic close_out();
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
    begin
      $display("TB: PASS");
    end
    else
    begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial
  begin
    tx_seq = 8'h00;
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    s_request();
    s_reject();
    s_tx();
    close_out();
  end
  initial
  begin
    #(40 * 30000);
    errors++;
    close_out();
  end
endmodule
bind serial_message_framer serial_message_framer_assertions chk_u (.sys_clk(sys_clk),
  .rst(rst), .ce(ce), .line_byte(line_byte), .line_valid(line_valid),
  .line_ready(line_ready), .tx_busy(tx_busy), .tx_data_take(tx_data_take),
  .rx_done(rx_done), .rx_body_valid(rx_body_valid));
`default_nettype wire
